// >>> dual_hbridge_params.svh
// Timing and reset constants for the dual H-bridge input decoder.
// Assumes a single 40 MHz core clock and the package that holds the types.
// How it works
// - All four inputs low puts the device in standby with every output off.
// - Per bridge: p-only forward, n-only reverse, both brake, none off.
// - Leaving standby runs a wake interval of about 7 us before outputs follow.
// - During the wake interval every output transistor stays switched off.
// - Enabling one bridge while the other already drives adds no wake delay.
// - Over-temperature trip forces all outputs off regardless of the inputs.
// - After a trip, outputs resume only once temperature drops by the hysteresis.
// - Bridge A inputs steer only bridge A outputs; bridge B likewise.
// - Bridge inputs are pulled low, so undriven inputs read as logic low.
`ifndef DUAL_HBRIDGE_PARAMS_SVH
`define DUAL_HBRIDGE_PARAMS_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_PERIOD_NS   25
`define WAKE_TIME_NS    7000
`define WAKE_CYCLES     ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CNT_W      9

// ==========================================================================
// Reset values
// ==========================================================================
`define SYNC_RESET_VAL  6'h00
`define DRIVE_OFF       2'h0

`endif

// >>> dual_hbridge_pkg.sv
// Types shared by the dual H-bridge decoder and its per-bridge decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package dual_hbridge_pkg;

   // One output half-bridge: on=1 drives level, on=0 leaves the pin off
   typedef struct packed {
      logic on;
      logic level;
   } drive_s;

   // One input pair of a bridge
   typedef struct packed {
      logic p;
      logic n;
   } bridge_in_s;

   // Power state of the whole device
   typedef enum logic [1:0] {
      ST_STANDBY,
      ST_WAKE,
      ST_RUN
   } power_state_e;

endpackage

// >>> bridge_decoder.sv
// Decodes one input pair into the registered drive of one H-bridge.
// Assumes synchronised inputs and an enable from the power controller.
`timescale 1ns/1ps
`include "dual_hbridge_params.svh"

module bridge_decoder
   import dual_hbridge_pkg::*;
(
   input  wire logic       core_clk,  // 40 MHz clock
   input  wire logic       rst,       // Async reset, active high
   input  wire logic       enable,    // Bridge may drive
   input  wire bridge_in_s ctrl,      // Synchronised input pair
   output drive_s          drive_p,   // First output of the bridge
   output drive_s          drive_n    // Second output of the bridge
);

   // ========================================================================
   // Decode
   // ========================================================================
   drive_s p_next;
   drive_s n_next;
   wire    fwd   = ctrl.p & ~ctrl.n;
   wire    rev   = ~ctrl.p & ctrl.n;
   wire    brake = ctrl.p & ctrl.n;
   wire    act   = enable & (ctrl.p | ctrl.n);

   // Forward, reverse, brake or off; brake pulls both low
   assign p_next = act ? drive_s'{on: 1'b1, level: fwd} : drive_s'(`DRIVE_OFF);
   assign n_next = act ? drive_s'{on: 1'b1, level: rev} : drive_s'(`DRIVE_OFF);

   // Output registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         drive_p <= `DRIVE_OFF;
         drive_n <= `DRIVE_OFF;
      end else begin
         drive_p <= p_next;
         drive_n <= n_next;
      end
   end

   // ========================================================================
   // Checks
   // ========================================================================
   AST_FORWARD: assert property (@(posedge core_clk) disable iff (rst)
      enable && fwd |=> drive_p == 2'h3 && drive_n == 2'h2)
      else $error("forward pattern not driven");
   AST_REVERSE: assert property (@(posedge core_clk) disable iff (rst)
      enable && rev |=> drive_p == 2'h2 && drive_n == 2'h3)
      else $error("reverse pattern not driven");
   AST_BRAKE: assert property (@(posedge core_clk) disable iff (rst)
      enable && brake |=> drive_p == 2'h2 && drive_n == 2'h2)
      else $error("brake pattern not driven");
   AST_IDLE_PAIR_OFF: assert property (@(posedge core_clk) disable iff (rst)
      !ctrl.p && !ctrl.n |=> !drive_p.on && !drive_n.on)
      else $error("idle pair not off");
   COV_BRAKE: cover property (@(posedge core_clk) disable iff (rst) enable && brake);

endmodule

// >>> dual_hbridge_input_decoder.sv
// Top of the two-channel H-bridge control logic: input sync, wake timer,
// thermal shutdown latch and two bridge decoders.
// Assumes asynchronous pins from a host and comparator levels from a sensor.
`timescale 1ns/1ps
`include "dual_hbridge_params.svh"

module dual_hbridge_input_decoder
   import dual_hbridge_pkg::*;
#(
   parameter int                   CNT_W       = `WAKE_CNT_W,   // Wake counter width
   parameter logic [CNT_W-1:0]     WAKE_CYCLES = CNT_W'(`WAKE_CYCLES) // Wake length
)(
   input  wire logic core_clk,            // 40 MHz clock
   input  wire logic rst,                 // Async reset, active high
   input  wire logic bridge_a_ctrl_p,     // Bridge A first input pin
   input  wire logic bridge_a_ctrl_n,     // Bridge A second input pin
   input  wire logic bridge_b_ctrl_p,     // Bridge B first input pin
   input  wire logic bridge_b_ctrl_n,     // Bridge B second input pin
   input  wire logic overtemp_trip,       // Die above shutdown point
   input  wire logic overtemp_hysteresis, // Die above release point
   output drive_s    bridge_a_drive_p,    // Bridge A first output
   output drive_s    bridge_a_drive_n,    // Bridge A second output
   output drive_s    bridge_b_drive_p,    // Bridge B first output
   output drive_s    bridge_b_drive_n     // Bridge B second output
);

   // ========================================================================
   // Input synchronisers
   // ========================================================================
   logic [5:0] meta_reg;
   logic [5:0] sync_reg;
   wire  [5:0] pins = {overtemp_hysteresis, overtemp_trip,
                       bridge_b_ctrl_p, bridge_b_ctrl_n,
                       bridge_a_ctrl_p, bridge_a_ctrl_n};

   // Two flops per pin; reset low matches the pad pull-downs
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= `SYNC_RESET_VAL;
         sync_reg <= `SYNC_RESET_VAL;
      end else begin
         meta_reg <= pins;
         sync_reg <= meta_reg;
      end
   end

   // Named views of the synchronised pins
   bridge_in_s in_a;
   bridge_in_s in_b;
   wire        trip_s = sync_reg[4];
   wire        hyst_s = sync_reg[5];
   assign in_a    = sync_reg[1:0];
   assign in_b    = sync_reg[3:2];
   wire   any_in  = |sync_reg[3:0];
   wire   all_low = ~any_in;

   // ========================================================================
   // Thermal shutdown latch
   // ========================================================================
   logic shut_reg;
   wire  shut_next = trip_s | (shut_reg & hyst_s);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shut_reg <= 1'b0;
      end else begin
         shut_reg <= shut_next;
      end
   end

   // ========================================================================
   // Power state and wake timer
   // ========================================================================
   power_state_e     state_reg;
   power_state_e     state_next;
   logic [CNT_W-1:0] wait_reg;
   logic [CNT_W-1:0] wait_next;

   // Standby on all-low, wake timer on first input, run thereafter
   always_comb begin
      state_next = state_reg;
      wait_next  = wait_reg;
      unique case (state_reg)
         ST_STANDBY: begin
            if (any_in) begin
               state_next = ST_WAKE;
               wait_next  = WAKE_CYCLES - CNT_W'(1);
            end
         end
         ST_WAKE: begin
            if (all_low) begin
               state_next = ST_STANDBY;
            end else if (wait_reg == '0) begin
               state_next = ST_RUN;
            end else begin
               wait_next = wait_reg - CNT_W'(1);
            end
         end
         ST_RUN: begin
            if (all_low) begin
               state_next = ST_STANDBY;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_STANDBY;
         wait_reg  <= '0;
      end else begin
         state_reg <= state_next;
         wait_reg  <= wait_next;
      end
   end

   // Outputs only in run without shutdown; other bridge joins with no delay
   wire drive_en = (state_reg == ST_RUN) & ~shut_reg;

   // ========================================================================
   // Bridge decoders, each pair steering only its own outputs
   // ========================================================================
   bridge_in_s bridge_in [2];
   drive_s     bridge_hi [2];
   drive_s     bridge_lo [2];

   // Index 0 is bridge A, index 1 is bridge B
   assign bridge_in[0] = in_a;
   assign bridge_in[1] = in_b;

   for (genvar g = 0; g < 2; g++) begin : gen_bridge
      bridge_decoder u_bridge (
         .core_clk (core_clk),
         .rst      (rst),
         .enable   (drive_en),
         .ctrl     (bridge_in[g]),
         .drive_p  (bridge_hi[g]),
         .drive_n  (bridge_lo[g])
      );
   end

   // Each decoder lands on its own pair of output pins
   assign bridge_a_drive_p = bridge_hi[0];
   assign bridge_a_drive_n = bridge_lo[0];
   assign bridge_b_drive_p = bridge_hi[1];
   assign bridge_b_drive_n = bridge_lo[1];

   // ========================================================================
   // Checks
   // ========================================================================
   wire              all_off = ~(bridge_a_drive_p.on | bridge_a_drive_n.on |
                                 bridge_b_drive_p.on | bridge_b_drive_n.on);
   logic [CNT_W:0]   wake_age_reg;

   // Counts consecutive wake cycles for the length check
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wake_age_reg <= '0;
      end else if (state_reg == ST_WAKE) begin
         wake_age_reg <= wake_age_reg + (CNT_W+1)'(1);
      end else begin
         wake_age_reg <= '0;
      end
   end

   AST_STANDBY_OFF: assert property (@(posedge core_clk) disable iff (rst)
      all_low |=> all_off && state_reg == ST_STANDBY)
      else $error("all-low inputs did not give standby with outputs off");
   AST_WAKE_ENTRY: assert property (@(posedge core_clk) disable iff (rst)
      state_reg == ST_STANDBY && any_in |=> state_reg == ST_WAKE)
      else $error("wake interval not started");
   AST_WAKE_LENGTH: assert property (@(posedge core_clk) disable iff (rst)
      state_reg == ST_RUN && $past(state_reg) == ST_WAKE |->
         $past(wake_age_reg) == (CNT_W+1)'(WAKE_CYCLES) - (CNT_W+1)'(1))
      else $error("wake interval length wrong");
   AST_WAKE_OFF: assert property (@(posedge core_clk) disable iff (rst)
      state_reg == ST_WAKE |=> all_off)
      else $error("output on during wake interval");
   AST_NO_REWAKE: assert property (@(posedge core_clk) disable iff (rst)
      state_reg == ST_RUN && any_in |=> state_reg == ST_RUN)
      else $error("wake delay inserted while running");
   AST_TRIP_OFF: assert property (@(posedge core_clk) disable iff (rst)
      trip_s |-> ##2 all_off)
      else $error("outputs on during thermal trip");
   AST_HYST_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      shut_reg && hyst_s |=> shut_reg)
      else $error("shutdown released above hysteresis point");
   AST_RESUME: assert property (@(posedge core_clk) disable iff (rst)
      shut_reg && !hyst_s && !trip_s |=> !shut_reg)
      else $error("shutdown not released after cooling");
   AST_PAIR_A_ONLY: assert property (@(posedge core_clk) disable iff (rst)
      drive_en && in_a == 2'h0 && in_b != 2'h0 |=> !bridge_a_drive_p.on && !bridge_a_drive_n.on)
      else $error("bridge A driven by bridge B inputs");
   // Standby, thermal and pairing checks
   AST_OFF_IN_STANDBY: assert property (@(posedge core_clk) disable iff (rst)
      state_reg == ST_STANDBY |=> all_off)
      else $error("output on in standby");
   AST_WAKE_ABORT: assert property (@(posedge core_clk) disable iff (rst)
      state_reg == ST_WAKE && all_low |=> state_reg == ST_STANDBY)
      else $error("all-low inputs during wake did not give standby");
   AST_SHUT_SET: assert property (@(posedge core_clk) disable iff (rst)
      trip_s |=> shut_reg)
      else $error("thermal trip did not set shutdown");
   AST_SHUT_OFF: assert property (@(posedge core_clk) disable iff (rst)
      shut_reg |=> all_off)
      else $error("output on during shutdown");
   AST_PAIR_B_ONLY: assert property (@(posedge core_clk) disable iff (rst)
      drive_en && in_b == 2'h0 && in_a != 2'h0 |=> !bridge_b_drive_p.on && !bridge_b_drive_n.on)
      else $error("bridge B driven by bridge A inputs");

   // ========================================================================
   // Main scenarios
   // ========================================================================
   COV_REACH_RUN: cover property (@(posedge core_clk) disable iff (rst)
      state_reg == ST_WAKE ##1 state_reg == ST_RUN);
   COV_WAKE_ABORT: cover property (@(posedge core_clk) disable iff (rst)
      state_reg == ST_WAKE ##1 state_reg == ST_STANDBY);
   COV_SHUTDOWN: cover property (@(posedge core_clk) disable iff (rst)
      drive_en ##1 shut_reg);
   COV_SECOND_BRIDGE: cover property (@(posedge core_clk) disable iff (rst)
      state_reg == ST_RUN && in_b == 2'h0 ##1 in_b != 2'h0);

endmodule

// >>> host_ctrl_model.sv
// Host controller model that drives the four bridge input pins.
// Assumes requests come from the bench and pins move just after a clock edge.
`timescale 1ns/1ps

module host_ctrl_model (
   input  wire logic       core_clk, // 40 MHz clock
   input  wire logic       rst,      // Async reset, active high
   input  wire logic [3:0] cmd,      // Requested pins {a_p,a_n,b_p,b_n}
   output logic            a_p,      // Bridge A first input
   output logic            a_n,      // Bridge A second input
   output logic            b_p,      // Bridge B first input
   output logic            b_n       // Bridge B second input
);
   // ==========================================================================
   // Pin driver
   // ==========================================================================
   // Each pair is held until the next request; low in reset as with pull-downs
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {a_p, a_n, b_p, b_n} <= 4'h0;
      end else begin
         {a_p, a_n, b_p, b_n} <= cmd;
      end
   end
endmodule

// >>> dual_hbridge_input_decoder_tb_top.sv
// Self-checking bench for the dual H-bridge input decoder.
// Assumes the host model file and a short wake parameter of 4 cycles.
`timescale 1ns/1ps

module dual_hbridge_input_decoder_tb_top;
   import dual_hbridge_pkg::*;
   localparam int WAKE_TB = 4; // Short wake length for the bench
   logic       core_clk;  // Bench clock
   logic       rst;       // Bench reset
   logic       trip;      // Over-temperature level
   logic       hyst;      // Release-point level
   logic [3:0] cmd;       // Host request
   logic       a_p, a_n, b_p, b_n;
   drive_s     oap, oan, obp, obn;
   wire  [7:0] out_now = {oap, oan, obp, obn};
   logic [7:0] seen;      // Outputs settled at the last falling edge
   int         bad_count;
   int         tests_run;
   int         seed;
   int         i;

   host_ctrl_model host_ctrl_model_i (.core_clk(core_clk), .rst(rst), .cmd(cmd),
      .a_p(a_p), .a_n(a_n), .b_p(b_p), .b_n(b_n));

   dual_hbridge_input_decoder #(.WAKE_CYCLES(9'(WAKE_TB))) dual_hbridge_input_decoder_i (
      .core_clk(core_clk), .rst(rst),
      .bridge_a_ctrl_p(a_p), .bridge_a_ctrl_n(a_n), .bridge_b_ctrl_p(b_p), .bridge_b_ctrl_n(b_n),
      .overtemp_trip(trip), .overtemp_hysteresis(hyst),
      .bridge_a_drive_p(oap), .bridge_a_drive_n(oan), .bridge_b_drive_p(obp), .bridge_b_drive_n(obn));

   // ==========================================================================
   // Helpers
   // ==========================================================================
   // Expected drive of one bridge from its input pair
   function automatic logic [3:0] bridge_exp(input logic [1:0] pn);
      case (pn)
         2'b10:   bridge_exp = 4'hE;
         2'b01:   bridge_exp = 4'hB;
         2'b11:   bridge_exp = 4'hA;
         default: bridge_exp = 4'h0;
      endcase
   endfunction

   function automatic logic [7:0] exp_of(input logic [3:0] c);
      exp_of = {bridge_exp(c[3:2]), bridge_exp(c[1:0])};
   endfunction

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic put(input logic [3:0] c);
      @(posedge core_clk);
      cmd <= c;
   endtask

   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ==========================================================================
   // Clock and watchdog
   // ==========================================================================
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Outputs are looked at only once settled, away from the launching edge
   always @(negedge core_clk) seen <= out_now;

   initial begin
      step(20000);
      bad_count++;
      final_report();
   end

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      rst = 1'b1;
      trip = 1'b0;
      hyst = 1'b0;
      cmd = 4'h0;
      bad_count = 0;
      tests_run = 0;
      seed = 31224;
      step(8);
      rst <= 1'b0;
      // Inputs drop back low inside the wake interval: stays off
      put(4'h4);
      put(4'h0);
      step(6);
      check("wake_abort", seen, 8'h00);
      // Wake from standby: off at first, then forward after the wake interval
      put(4'h8);
      step(7);
      check("wake_off", seen, 8'h00);
      i = 0;
      while (seen[7] !== 1'b1 && i < 20) begin
         step(1);
         i++;
      end
      if (i == 20) begin
         bad_count++;
      end
      check("wake_len", 8'(i), 8'(WAKE_TB - 1));
      check("wake_fwd", seen, exp_of(4'h8));
      // Second bridge joins with no wake delay
      put(4'hA);
      step(6);
      check("join_b", seen, exp_of(4'hA));
      // Every nonzero pattern of both pairs
      for (int c = 1; c < 16; c++) begin
         put(c[3:0]);
         step(12);
         check("pattern", seen, exp_of(c[3:0]));
      end
      put(4'h0);
      step(6);
      check("standby", seen, 8'h00);
      // Random patterns, standby and rewake among them
      repeat (40) begin
         put(4'($random(seed)));
         step(14);
         check("random", seen, exp_of(cmd));
      end
      // Thermal trip, hold by hysteresis, then release
      put(4'h6);
      step(14);
      trip <= 1'b1;
      hyst <= 1'b1;
      step(6);
      check("trip_off", seen, 8'h00);
      trip <= 1'b0;
      step(8);
      check("hyst_hold", seen, 8'h00);
      hyst <= 1'b0;
      step(8);
      check("released", seen, exp_of(4'h6));
      final_report();
   end
endmodule
